// >>> shared/ppmux_defines.svh
// Constants of the port pin output multiplexer: offsets, resets, fields, codes.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef PPMUX_DEFINES_SVH
`define PPMUX_DEFINES_SVH

// ****************************************************************
// Register offsets inside the register page
// ****************************************************************
`define PPMUX_ADDR_PAGE   8'h80
`define PPMUX_ADDR_PIN01  8'h81
`define PPMUX_ADDR_PIN23  8'h82
`define PPMUX_ADDR_CTRL   8'h83
`define PPMUX_ADDR_RUN01  8'h84
`define PPMUX_ADDR_RUN23  8'h85

// ****************************************************************
// Reset values
// ****************************************************************
`define PPMUX_RST_PAGE    2'h0
`define PPMUX_RST_PIN01   8'h50
`define PPMUX_RST_PIN23   8'h12
`define PPMUX_RST_CTRL    8'h00
`define PPMUX_RST_RUN     8'hFF
`define PPMUX_RD_NONE     8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define PPMUX_PAGE_FLD    1:0
`define PPMUX_LO_NIB      3:0
`define PPMUX_HI_NIB      7:4
`define PPMUX_INV_FLD     3:0
`define PPMUX_PAGE_PAD    6'h00

// ****************************************************************
// Source selection codes
// ****************************************************************
`define PPMUX_SRC_CLK     4'h0
`define PPMUX_SRC_RUN     4'h1
`define PPMUX_SRC_INT     4'h2
`define PPMUX_SRC_LOW     4'h3
`define PPMUX_SRC_HIGH    4'h4
`define PPMUX_SRC_DATA    4'h5
`define PPMUX_SRC_MFD     4'h6
`define PPMUX_SRC_CHD     4'h8
`define PPMUX_SRC_CHS     4'h9
`define PPMUX_SRC_RXD     4'hA
`define PPMUX_SRC_RXS     4'hB

`endif

// >>> shared/ppmux_pkg.sv
// Types shared by the port pin output multiplexer files.
// Assumes ppmux_defines.svh is on the include path.
`include "ppmux_defines.svh"

package ppmux_pkg;

    // Source codes of a pin selection field
    typedef enum logic [3:0] {
        PPMUX_CLK  = `PPMUX_SRC_CLK,
        PPMUX_RUN  = `PPMUX_SRC_RUN,
        PPMUX_INT  = `PPMUX_SRC_INT,
        PPMUX_LOW  = `PPMUX_SRC_LOW,
        PPMUX_HIGH = `PPMUX_SRC_HIGH,
        PPMUX_DATA = `PPMUX_SRC_DATA,
        PPMUX_MFD  = `PPMUX_SRC_MFD,
        PPMUX_CHD  = `PPMUX_SRC_CHD,
        PPMUX_CHS  = `PPMUX_SRC_CHS,
        PPMUX_RXD  = `PPMUX_SRC_RXD,
        PPMUX_RXS  = `PPMUX_SRC_RXS
    } ppmux_src_type;

    // Internal signals offered to every pin
    typedef struct packed {
        logic clk_out;
        logic run;
        logic int_n;
        logic data;
        logic mfd;
        logic chd;
        logic chs;
        logic rxd;
        logic rxs;
    } ppmux_srcs_type;

endpackage : ppmux_pkg

// >>> hdl/ppmux_level_sel.sv
// Picks one pin's receiver-run active level for the active configuration.
// Assumes the four level bits are ordered A in bit 0 up to D in bit 3.
`timescale 1ns/1ps

module ppmux_level_sel
    import ppmux_pkg::*;
(
    input  wire logic [3:0] level_bits,
    input  wire logic [1:0] cfg,
    output logic            level
);

    // Index by configuration code
    assign level = level_bits[cfg];

endmodule : ppmux_level_sel

// >>> hdl/ppmux_pin_sel.sv
// One port pin: source selection, run polarity, inversion, output flop.
// Assumes all sources come from logic on the same clock.
`timescale 1ns/1ps
`include "ppmux_defines.svh"

module ppmux_pin_sel
    import ppmux_pkg::*;
#(
    parameter bit CLK_OK = 1'b1
)
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic [3:0]     sel,
    input  wire logic           invert,
    input  wire logic           run_level,
    input  wire ppmux_srcs_type srcs,
    output logic                pin_q
);

    logic pin_d;
    logic chosen;

    // Selection; unused codes give a static low before inversion
    always_comb
    begin
        chosen = 1'b0;
        unique case (sel)
            `PPMUX_SRC_CLK:  chosen = CLK_OK ? srcs.clk_out : 1'b0; // R5 R6
            `PPMUX_SRC_RUN:  chosen = srcs.run ~^ run_level;        // R10
            `PPMUX_SRC_INT:  chosen = srcs.int_n;
            `PPMUX_SRC_LOW:  chosen = 1'b0;
            `PPMUX_SRC_HIGH: chosen = 1'b1;
            `PPMUX_SRC_DATA: chosen = srcs.data;
            `PPMUX_SRC_MFD:  chosen = srcs.mfd;
            `PPMUX_SRC_CHD:  chosen = srcs.chd;
            `PPMUX_SRC_CHS:  chosen = srcs.chs;
            `PPMUX_SRC_RXD:  chosen = srcs.rxd;
            `PPMUX_SRC_RXS:  chosen = srcs.rxs;
            default:         chosen = 1'b0; // R3 R9
        endcase
    end

    // Inversion follows the selection
    assign pin_d = chosen ^ invert; // R8 R9

    // Registered pin drive, glitch free across selection changes
    always_ff @(posedge clk)
    begin
        if (rst)
            pin_q <= 1'b0;
        else
            pin_q <= pin_d;
    end

endmodule : ppmux_pin_sel

// >>> hdl/ppmux_top.sv
// Port pin output multiplexer: page register, pin source and control registers.
// Assumes the serial front end delivers one-cycle REG_WR / REG_RD strobes with
// an 8-bit offset, and all internal sources are synchronous to CLOCK.
//
// What this block does
// R1 - Two-bit page field selects configuration page
// R2 - Pin 1 field bits 7:4 selects source
// R3 - Pin 0 field bits 3:0, unused codes inert
// R4 - Pin 0/1 register resets to 0x50
// R5 - Pin 3 field: no clock out, resets run
// R6 - Pin 2 field full selection, resets interrupt
// R7 - Pin 2/3 register resets to 0x12
// R8 - Control bits 3:0 invert pins 3..0
// R9 - Inversion after selection; unused codes low
// R10 - Run polarity from per-configuration level bit
`timescale 1ns/1ps
`include "ppmux_defines.svh"

module ppmux_top
    import ppmux_pkg::*;
(
    input  wire logic       CLOCK,
    input  wire logic       SYS_RST,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic      [1:0] CFG_PAGE,
    input  wire logic [1:0] ACTIVE_CFG,
    input  wire logic       CLK_OUT,
    input  wire logic       RX_RUN,
    input  wire logic       INTERRUPT_OUT_N,
    input  wire logic       DATA,
    input  wire logic       MATCHED_FILTER_DATA,
    input  wire logic       CHIP_DATA,
    input  wire logic       CHIP_STROBE,
    input  wire logic       RX_DATA,
    input  wire logic       RECEIVE_STROBE,
    output logic      [3:0] PP_OUT
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [1:0]     page_select_field_q;
    logic [7:0]     pin01_source_register_q;
    logic [7:0]     pin23_source_register_q;
    logic [7:0]     pin_control_register_q;
    logic [7:0]     run_level_01_q;
    logic [7:0]     run_level_23_q;
    logic [7:0]     rdata_d;
    logic [7:0]     rdata_q;
    logic [3:0]     pin_invert;
    logic [3:0]     run_level;
    logic [3:0]     pin_out;
    ppmux_srcs_type srcs;

    // Address match helper, used by every write decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_off);
        hit = (addr == reg_off);
    endfunction : hit

    // ****************************************************************
    // Register writes
    // ****************************************************************

    // Page select; common registers answer on every page
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            page_select_field_q <= `PPMUX_RST_PAGE;
        else if (REG_WR && hit(REG_ADDR, `PPMUX_ADDR_PAGE))
            page_select_field_q <= REG_WDATA[`PPMUX_PAGE_FLD]; // R1
    end

    // Pin 0 and pin 1 source fields
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            pin01_source_register_q <= `PPMUX_RST_PIN01; // R4
        else if (REG_WR && hit(REG_ADDR, `PPMUX_ADDR_PIN01))
            pin01_source_register_q <= REG_WDATA; // R2 R3
    end

    // Pin 2 and pin 3 source fields
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            pin23_source_register_q <= `PPMUX_RST_PIN23; // R5 R6 R7
        else if (REG_WR && hit(REG_ADDR, `PPMUX_ADDR_PIN23))
            pin23_source_register_q <= REG_WDATA;
    end

    // Pin control: drive strength bits are stored only, pad is elsewhere
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            pin_control_register_q <= `PPMUX_RST_CTRL; // R8
        else if (REG_WR && hit(REG_ADDR, `PPMUX_ADDR_CTRL))
            pin_control_register_q <= REG_WDATA;
    end

    // Run level bits, all active high out of reset
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            run_level_01_q <= `PPMUX_RST_RUN; // R10
            run_level_23_q <= `PPMUX_RST_RUN;
        end
        else if (REG_WR && hit(REG_ADDR, `PPMUX_ADDR_RUN01))
            run_level_01_q <= REG_WDATA;
        else if (REG_WR && hit(REG_ADDR, `PPMUX_ADDR_RUN23))
            run_level_23_q <= REG_WDATA;
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************

    // Read mux; unmapped offsets and unused page bits read zero
    always_comb
    begin
        rdata_d = `PPMUX_RD_NONE;
        unique case (REG_ADDR)
            `PPMUX_ADDR_PAGE:  rdata_d = {`PPMUX_PAGE_PAD, page_select_field_q};
            `PPMUX_ADDR_PIN01: rdata_d = pin01_source_register_q;
            `PPMUX_ADDR_PIN23: rdata_d = pin23_source_register_q;
            `PPMUX_ADDR_CTRL:  rdata_d = pin_control_register_q;
            `PPMUX_ADDR_RUN01: rdata_d = run_level_01_q;
            `PPMUX_ADDR_RUN23: rdata_d = run_level_23_q;
            default:           rdata_d = `PPMUX_RD_NONE;
        endcase
    end

    // Read data held until the next read strobe
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            rdata_q <= `PPMUX_RD_NONE;
        else if (REG_RD)
            rdata_q <= rdata_d;
    end

    assign REG_RDATA = rdata_q;
    assign CFG_PAGE  = page_select_field_q; // R1

    // ****************************************************************
    // Pin multiplexers
    // ****************************************************************

    // Gather the internal sources
    assign srcs.clk_out = CLK_OUT;
    assign srcs.run     = RX_RUN;
    assign srcs.int_n   = INTERRUPT_OUT_N;
    assign srcs.data    = DATA;
    assign srcs.mfd     = MATCHED_FILTER_DATA;
    assign srcs.chd     = CHIP_DATA;
    assign srcs.chs     = CHIP_STROBE;
    assign srcs.rxd     = RX_DATA;
    assign srcs.rxs     = RECEIVE_STROBE;

    assign pin_invert = pin_control_register_q[`PPMUX_INV_FLD];

    // Per-pin run polarity for the configuration in use
    ppmux_level_sel u_lvl0 (
        .level_bits (run_level_01_q[`PPMUX_LO_NIB]),
        .cfg        (ACTIVE_CFG),
        .level      (run_level[0])
    );
    ppmux_level_sel u_lvl1 (
        .level_bits (run_level_01_q[`PPMUX_HI_NIB]),
        .cfg        (ACTIVE_CFG),
        .level      (run_level[1])
    );
    ppmux_level_sel u_lvl2 (
        .level_bits (run_level_23_q[`PPMUX_LO_NIB]),
        .cfg        (ACTIVE_CFG),
        .level      (run_level[2])
    );
    ppmux_level_sel u_lvl3 (
        .level_bits (run_level_23_q[`PPMUX_HI_NIB]),
        .cfg        (ACTIVE_CFG),
        .level      (run_level[3])
    );

    // Pin 0, full selection
    ppmux_pin_sel #(.CLK_OK(1'b1)) u_pin0 (
        .clk       (CLOCK),
        .rst       (SYS_RST),
        .sel       (pin01_source_register_q[`PPMUX_LO_NIB]), // R3
        .invert    (pin_invert[0]),
        .run_level (run_level[0]),
        .srcs      (srcs),
        .pin_q     (pin_out[0])
    );

    // Pin 1, full selection
    ppmux_pin_sel #(.CLK_OK(1'b1)) u_pin1 (
        .clk       (CLOCK),
        .rst       (SYS_RST),
        .sel       (pin01_source_register_q[`PPMUX_HI_NIB]), // R2
        .invert    (pin_invert[1]),
        .run_level (run_level[1]),
        .srcs      (srcs),
        .pin_q     (pin_out[1])
    );

    // Pin 2, clock out allowed
    ppmux_pin_sel #(.CLK_OK(1'b1)) u_pin2 (
        .clk       (CLOCK),
        .rst       (SYS_RST),
        .sel       (pin23_source_register_q[`PPMUX_LO_NIB]), // R6
        .invert    (pin_invert[2]),
        .run_level (run_level[2]),
        .srcs      (srcs),
        .pin_q     (pin_out[2])
    );

    // Pin 3, clock out code is unused here
    ppmux_pin_sel #(.CLK_OK(1'b0)) u_pin3 (
        .clk       (CLOCK),
        .rst       (SYS_RST),
        .sel       (pin23_source_register_q[`PPMUX_HI_NIB]), // R5
        .invert    (pin_invert[3]),
        .run_level (run_level[3]),
        .srcs      (srcs),
        .pin_q     (pin_out[3])
    );

    assign PP_OUT = pin_out;

    // ****************************************************************
    // Assertions and cover points
    // ****************************************************************

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    logic [3:0] p0_sel;
    logic [3:0] p1_sel;
    logic [3:0] p2_sel;
    logic [3:0] p3_sel;
    assign p0_sel = pin01_source_register_q[`PPMUX_LO_NIB];
    assign p1_sel = pin01_source_register_q[`PPMUX_HI_NIB];
    assign p2_sel = pin23_source_register_q[`PPMUX_LO_NIB];
    assign p3_sel = pin23_source_register_q[`PPMUX_HI_NIB];

    // Reset checks must see the cycle after reset
    logic rst_seen_q;
    always_ff @(posedge CLOCK)
    begin
        rst_seen_q <= SYS_RST;
    end

    chk_page_write: assert property ( // R1
        REG_WR && REG_ADDR == `PPMUX_ADDR_PAGE
            |=> CFG_PAGE == $past(REG_WDATA[`PPMUX_PAGE_FLD])
    ) else $error("page field not taken from write");

    chk_pin01_reset: assert property (@(posedge CLOCK) // R4
        rst_seen_q && !SYS_RST |-> pin01_source_register_q == `PPMUX_RST_PIN01
    ) else $error("pin 0/1 register reset value wrong");

    chk_pin23_reset: assert property (@(posedge CLOCK) // R7
        rst_seen_q && !SYS_RST |-> pin23_source_register_q == `PPMUX_RST_PIN23
            && run_level_01_q == `PPMUX_RST_RUN && pin_control_register_q == `PPMUX_RST_CTRL
    ) else $error("pin 2/3, run or control reset value wrong");

    chk_pin1_data: assert property ( // R2
        p1_sel == `PPMUX_SRC_DATA && !pin_invert[1] |=> PP_OUT[1] == $past(DATA)
    ) else $error("pin 1 does not follow data");

    chk_pin0_low: assert property ( // R3
        p0_sel == `PPMUX_SRC_LOW ##0 pin_invert[0] |=> PP_OUT[0]
    ) else $error("inverted constant low on pin 0 not high");

    chk_pin3_noclk: assert property ( // R5
        p3_sel == `PPMUX_SRC_CLK && !pin_invert[3] |=> !PP_OUT[3]
    ) else $error("pin 3 passes clock out");

    chk_pin2_clk: assert property ( // R6
        p2_sel == `PPMUX_SRC_CLK && !pin_invert[2] |=> PP_OUT[2] == $past(CLK_OUT)
    ) else $error("pin 2 does not pass clock out");

    chk_high_invert: assert property ( // R8
        p1_sel == `PPMUX_SRC_HIGH && pin_invert[1] |=> !PP_OUT[1]
    ) else $error("inverted constant high on pin 1 not low");

    chk_unused_low: assert property ( // R9
        p2_sel >= 4'hC && !pin_invert[2] [*2] |=> !PP_OUT[2]
    ) else $error("unused code on pin 2 not low");

    chk_run_level: assert property ( // R10
        p0_sel == `PPMUX_SRC_RUN && !pin_invert[0]
            |=> PP_OUT[0] == ($past(RX_RUN) ~^ $past(run_level[0]))
    ) else $error("run polarity on pin 0 wrong");

    chk_ctrl_read: assert property ( // R8
        REG_RD && REG_ADDR == `PPMUX_ADDR_CTRL |=> REG_RDATA == $past(pin_control_register_q)
    ) else $error("control register read back wrong");

    cov_pin1_data:   cover property (p1_sel == `PPMUX_SRC_DATA ##1 PP_OUT[1]);
    cov_page_change: cover property (CFG_PAGE == 2'h0 ##1 CFG_PAGE == 2'h3);
    cov_run_low:     cover property (p0_sel == `PPMUX_SRC_RUN && !run_level[0]);
    cov_invert_all:  cover property (pin_invert == 4'hF);

endmodule : ppmux_top

// >>> tb/ppmux_src_model.sv
// Model of the internal signal sources that feed the port pin multiplexer.
// Assumes one clock; sources change on the falling edge, away from sampling.
`timescale 1ns/1ps

module ppmux_src_model
(
    input  wire logic clk,
    input  wire logic rst,
    output logic      clk_out,
    output logic      run,
    output logic      int_n,
    output logic      data,
    output logic      mfd,
    output logic      chd,
    output logic      chs,
    output logic      rxd,
    output logic      rxs
);
    logic [8:0] pat_q;

    // Shift pattern, so every source toggles in its own rhythm
    always_ff @(negedge clk)
    begin
        if (rst)
            pat_q <= 9'h1A5;
        else
            pat_q <= {pat_q[7:0], pat_q[8] ^ pat_q[4]};
    end

    assign {clk_out, run, int_n, data, mfd, chd, chs, rxd, rxs} = pat_q;
endmodule : ppmux_src_model

// >>> tb/testbench.sv
// Self-checking bench for the port pin multiplexer: register reads and writes,
// source codes, inversion and run polarity. Assumes ppmux_defines.svh on path.
`timescale 1ns/1ps
`include "ppmux_defines.svh"

module testbench;
    logic       CLOCK = 1'b0;
    logic       SYS_RST = 1'b1;
    logic       REG_WR = 1'b0;
    logic       REG_RD = 1'b0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic [7:0] REG_RDATA;
    logic [1:0] CFG_PAGE;
    logic [1:0] ACTIVE_CFG = 2'h0;
    logic [3:0] PP_OUT;
    logic       s_clk, s_run, s_int, s_dat, s_mfd, s_chd, s_chs, s_rxd, s_rxs;
    logic [1:0] page_m;
    logic [7:0] p01_m, p23_m, ctrl_m, r01_m, r23_m, rd;
    int         n_mismatch = 0;
    int         n_checks = 0;

    // ****************************************************************
    // Clock, sources, design
    // ****************************************************************
    always #5 CLOCK = ~CLOCK;

    ppmux_src_model u_src (.clk(CLOCK), .rst(SYS_RST), .clk_out(s_clk), .run(s_run),
        .int_n(s_int), .data(s_dat), .mfd(s_mfd), .chd(s_chd), .chs(s_chs),
        .rxd(s_rxd), .rxs(s_rxs));

    ppmux_top u_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .CFG_PAGE(CFG_PAGE), .ACTIVE_CFG(ACTIVE_CFG), .CLK_OUT(s_clk), .RX_RUN(s_run),
        .INTERRUPT_OUT_N(s_int), .DATA(s_dat), .MATCHED_FILTER_DATA(s_mfd),
        .CHIP_DATA(s_chd), .CHIP_STROBE(s_chs), .RX_DATA(s_rxd), .RECEIVE_STROBE(s_rxs),
        .PP_OUT(PP_OUT));

    // ****************************************************************
    // Reporting
    // ****************************************************************
    task automatic give_verdict();
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_pins(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: pins %b, expected %b", $time, got, exp);
        end
    endtask : cmp_pins

    // ****************************************************************
    // Register access, entered and left at a falling edge
    // ****************************************************************
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(negedge CLOCK);
        REG_WR = 1'b0;
        case (a)
            `PPMUX_ADDR_PAGE:  page_m = d[1:0];
            `PPMUX_ADDR_PIN01: p01_m = d;
            `PPMUX_ADDR_PIN23: p23_m = d;
            `PPMUX_ADDR_CTRL:  ctrl_m = d;
            `PPMUX_ADDR_RUN01: r01_m = d;
            `PPMUX_ADDR_RUN23: r23_m = d;
            default: ;
        endcase
        // Idle cycle, so a following call never re-raises the strobe in this step
        @(negedge CLOCK);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLOCK);
        REG_RD = 1'b0;
        d = REG_RDATA;
        // Idle cycle between strobes
        @(negedge CLOCK);
    endtask : reg_read

    // Expected readback; unmapped offsets and page bits 7:2 read zero
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            `PPMUX_ADDR_PAGE:  return {6'h00, page_m};
            `PPMUX_ADDR_PIN01: return p01_m;
            `PPMUX_ADDR_PIN23: return p23_m;
            `PPMUX_ADDR_CTRL:  return ctrl_m;
            `PPMUX_ADDR_RUN01: return r01_m;
            `PPMUX_ADDR_RUN23: return r23_m;
            default:           return 8'h00;
        endcase
    endfunction : exp_rd

    // Expected level of one pin from the sources at the sampling edge
    function automatic logic exp_pin(input int i);
        logic [3:0] c;
        logic       lvl;
        logic       v;
        c = (i < 2) ? p01_m[i*4 +: 4] : p23_m[(i-2)*4 +: 4];
        lvl = (i < 2) ? r01_m[i*4 + ACTIVE_CFG] : r23_m[(i-2)*4 + ACTIVE_CFG];
        case (c)
            `PPMUX_SRC_CLK:  v = (i == 3) ? 1'b0 : s_clk;
            `PPMUX_SRC_RUN:  v = lvl ? s_run : ~s_run;
            `PPMUX_SRC_INT:  v = s_int;
            `PPMUX_SRC_LOW:  v = 1'b0;
            `PPMUX_SRC_HIGH: v = 1'b1;
            `PPMUX_SRC_DATA: v = s_dat;
            `PPMUX_SRC_MFD:  v = s_mfd;
            `PPMUX_SRC_CHD:  v = s_chd;
            `PPMUX_SRC_CHS:  v = s_chs;
            `PPMUX_SRC_RXD:  v = s_rxd;
            `PPMUX_SRC_RXS:  v = s_rxs;
            default:         v = 1'b0;
        endcase
        return v ^ ctrl_m[i];
    endfunction : exp_pin

    // Pins checked just after each edge, sources unchanged until the fall
    task automatic check_pins(input int n);
        repeat (n)
        begin
            @(posedge CLOCK);
            #1;
            cmp_pins(PP_OUT, {exp_pin(3), exp_pin(2), exp_pin(1), exp_pin(0)});
        end
        @(negedge CLOCK);
    endtask : check_pins

    // Reset for four cycles, then every register compared with its reset value
    task automatic do_reset();
        SYS_RST = 1'b1;
        repeat (4) @(negedge CLOCK);
        SYS_RST = 1'b0;
        page_m = `PPMUX_RST_PAGE;
        p01_m = `PPMUX_RST_PIN01;
        p23_m = `PPMUX_RST_PIN23;
        ctrl_m = `PPMUX_RST_CTRL;
        r01_m = `PPMUX_RST_RUN;
        r23_m = `PPMUX_RST_RUN;
        for (int a = 8'h80; a <= 8'h86; a++)
        begin
            reg_read(8'(a), rd);
            cmp_byte(rd, exp_rd(8'(a)));
        end
        cmp_byte({6'h00, CFG_PAGE}, 8'h00);
        check_pins(4);
    endtask : do_reset

    // ****************************************************************
    // Watchdog: a hang counts as a mismatch
    // ****************************************************************
    initial
    begin
        repeat (20000) @(posedge CLOCK);
        n_mismatch++;
        give_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        @(negedge CLOCK);
        do_reset();
        // Page codes, with upper bits written high to prove they stay zero
        for (int i = 0; i < 5; i++)
        begin
            reg_write(`PPMUX_ADDR_PAGE, (i == 4) ? 8'hFE : 8'(i));
            reg_read(`PPMUX_ADDR_PAGE, rd);
            cmp_byte(rd, exp_rd(`PPMUX_ADDR_PAGE));
            cmp_byte({6'h00, CFG_PAGE}, {6'h00, page_m});
        end
        // Mixed run levels so both polarities show up
        reg_write(`PPMUX_ADDR_RUN01, 8'h5A);
        reg_write(`PPMUX_ADDR_RUN23, 8'hC3);
        // Every code on every pin, under four inversion patterns
        for (int v = 0; v < 4; v++)
        begin
            reg_write(`PPMUX_ADDR_CTRL, 8'(v * 5) ^ 8'hF0);
            for (int c = 0; c < 16; c++)
            begin
                ACTIVE_CFG = 2'(c + v);
                reg_write(`PPMUX_ADDR_PIN01, {4'(c), 4'(c)});
                reg_write(`PPMUX_ADDR_PIN23, {4'(15 - c), 4'(c)});
                check_pins(3);
            end
        end
        // Run selected on all pins, each configuration in turn
        reg_write(`PPMUX_ADDR_PIN01, 8'h11);
        reg_write(`PPMUX_ADDR_PIN23, 8'h11);
        for (int g = 0; g < 4; g++)
        begin
            ACTIVE_CFG = 2'(g);
            check_pins(4);
        end
        // Unmapped write ignored, mapped registers unchanged
        reg_write(8'h86, 8'hAA);
        for (int a = 8'h80; a <= 8'h86; a++)
        begin
            reg_read(8'(a), rd);
            cmp_byte(rd, exp_rd(8'(a)));
        end
        // Second reset in mid-run
        do_reset();
        give_verdict();
    end
endmodule : testbench
